// *** inc/wes_pkg.sv ***
// Constants shared by the wake event enable and status block.
// Assumes one 50 MHz clock and an 8-bit register port from the host side.
package wes_pkg;
  localparam int unsigned ADDR_W = 8;         // Register address width
  localparam int unsigned DATA_W = 8;         // Register data width
  localparam int unsigned GP_N   = 8;         // General event sources
  localparam int unsigned MAIN_N = 3;         // Button, alarm, override
  // Register offsets
  localparam logic [7:0] OFS_MAIN_STATUS   = 8'h70;
  localparam logic [7:0] OFS_MAIN_MASK     = 8'h71;
  localparam logic [7:0] OFS_GP_MASK       = 8'h72;
  localparam logic [7:0] OFS_GP_POLARITY   = 8'h73;
  localparam logic [7:0] OFS_SUPPLY_CTRL   = 8'h74;
  localparam logic [7:0] OFS_ENABLE_RSVD   = 8'h7a;
  localparam logic [7:0] OFS_ENABLE_MAIN   = 8'h7b;
  localparam logic [7:0] OFS_GP_STATUS_LOW = 8'h7c;
  // Field positions in the enable and main status layout
  localparam int unsigned BIT_BUTTON   = 0;
  localparam int unsigned BIT_ALARM    = 2;
  localparam int unsigned BIT_OVERRIDE = 3;
  localparam int unsigned BIT_SLEEP    = 0;   // Supply control write bit
  localparam int unsigned BIT_SUPPLY   = 0;   // Supply control read bit
  // Index of each source in the main flag vector
  localparam int unsigned MI_BUTTON   = 0;
  localparam int unsigned MI_ALARM    = 1;
  localparam int unsigned MI_OVERRIDE = 2;
  // Reset value and valid enable bits
  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam logic [7:0] ENABLE_VALID = 8'h05; // Only bits 0 and 2 exist
  // Sources whose documented edge is high-to-low
  localparam logic [GP_N-1:0]   GP_FALL_DEFAULT   = 8'h58;
  localparam logic [MAIN_N-1:0] MAIN_FALL_DEFAULT = 3'h1;
endpackage : wes_pkg

// *** inc/wes_evt_if.sv ***
// Carrier between the event detector, the flag bank and the top.
// Assumes all three sit on core_clk.
`timescale 1ns/1ns
interface wes_evt_if #(parameter int unsigned W = 8);
  logic [W-1:0] raw;       // Unsynchronised source levels
  logic [W-1:0] invert;    // Per-source polarity inversion
  logic [W-1:0] hit;       // One-cycle edge found
  logic [W-1:0] clr;       // Clear requests
  logic [W-1:0] rst_bits;  // Per-bit reset
  logic [W-1:0] flags;     // Sticky flags
  modport det (input raw, input invert, output hit);
  modport flg (input hit, input clr, input rst_bits, output flags);
  modport ctl (output raw, output invert, output clr, output rst_bits,
               input hit, input flags);
endinterface : wes_evt_if

// *** rtl/wes_edge_detect.sv ***
// Two-stage synchroniser and edge finder per source.
// Assumes raw levels are asynchronous to core_clk.
`timescale 1ns/1ns
module wes_edge_detect #(
  parameter int unsigned W = 8                // Source count
) (
  input  wire logic core_clk,                 // System clock
  input  wire logic reset,                    // Synchronous reset
  wes_evt_if.det    ev                        // Source carrier
);
  logic [W-1:0] sync_a;    // First stage, read only by sync_b
  logic [W-1:0] sync_b;    // Second stage
  logic [W-1:0] prev;      // Previous polarity-corrected sample
  logic [W-1:0] level;     // Polarity-corrected present sample

  initial begin
    if (W < 1) $error("wes_edge_detect needs at least one source");
  end

  // Synchronise every source; no reset, so the stages hold the true
  // pin level when reset ends and a pin held active gives no edge
  always_ff @(posedge core_clk) begin
    sync_a <= ev.raw;
    sync_b <= sync_a;
  end

  // Inversion turns the opposite edge into a rising one
  assign level = sync_b ^ ev.invert;

  // Ones at reset so no edge fires before an idle level is seen
  always_ff @(posedge core_clk) begin
    if (reset) prev <= '1;
    else prev <= level;
  end

  assign ev.hit = level & ~prev;
endmodule : wes_edge_detect

// *** rtl/wes_flag_bank.sv ***
// Bank of sticky flags, set by edges, cleared by one-writes.
// Assumes hit, clr and rst_bits all come from core_clk logic.
`timescale 1ns/1ns
module wes_flag_bank #(
  parameter int unsigned W = 8                // Flag count
) (
  input  wire logic core_clk,                 // System clock
  wes_evt_if.flg    ev                        // Flag carrier
);
  initial begin
    if (W < 1) $error("wes_flag_bank needs at least one flag");
  end

  // One flag per source; set beats clear in the same cycle
  for (genvar i = 0; i < W; i++) begin : g_flag
    always_ff @(posedge core_clk) begin
      if (ev.rst_bits[i]) ev.flags[i] <= 1'b0;
      else if (ev.hit[i]) ev.flags[i] <= 1'b1;
      else if (ev.clr[i]) ev.flags[i] <= 1'b0;
    end
  end
endmodule : wes_flag_bank

// *** rtl/wes_wake_top.sv ***
// Wake event enables, event status and wake outputs.
// Assumes host register port on core_clk and asynchronous event pins.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ns
module wes_wake_top
  import wes_pkg::*;
(
  input  wire logic              core_clk,              // 50 MHz clock
  input  wire logic              reset,                 // Standby power reset
  input  wire logic              battery_reset,         // Battery power reset
  input  wire logic [ADDR_W-1:0] reg_addr,              // Register address
  input  wire logic [DATA_W-1:0] reg_wdata,             // Write data
  input  wire logic              reg_wr,                // Write strobe
  input  wire logic              reg_rd,                // Read strobe
  output logic      [DATA_W-1:0] reg_rdata,             // Read data, next cycle
  input  wire logic              power_button_input_n,  // Button, low pressed
  input  wire logic              alarm_in,              // Clock alarm level
  input  wire logic              override_in,           // Override indication
  input  wire logic [2:0]        gp_pin,                // Pins a, b, c
  input  wire logic              keyboard_data,         // Keyboard data line
  input  wire logic              mouse_data,            // Mouse data line
  input  wire logic              special_key,           // Special key event
  input  wire logic              ring_indicator_n,      // Ring indicator
  input  wire logic              combined_event,        // All events signal
  output logic                   supply_on_output_n,    // Supply on, low on
  output logic                   power_event_output_n,  // Power event, low
  output logic                   wake_pulse,            // Wake strobe
  output logic                   irq                    // Level interrupt
);

  // Carriers for the general sources and for the main sources
  wes_evt_if #(.W(GP_N))   gp_ev ();
  wes_evt_if #(.W(MAIN_N)) mn_ev ();

  // Software-visible state
  logic [DATA_W-1:0] enable_main;   // Button and alarm enables
  logic [DATA_W-1:0] main_mask;     // Interrupt mask for main status
  logic [GP_N-1:0]   gp_mask;       // Interrupt mask for general status
  logic [GP_N-1:0]   gp_polarity;   // Per-source inversion
  logic [DATA_W-1:0] main_status;   // Main flags in register layout
  logic              supply_on;     // Supply currently requested on

  // Decoded accesses
  logic              wr_enable;     // Write to main enable
  logic              wr_gp_stat;    // Write to general status
  logic              wr_mn_stat;    // Write to main status
  logic              wr_mn_mask;    // Write to main mask
  logic              wr_gp_mask;    // Write to general mask
  logic              wr_polarity;   // Write to polarity
  logic              wr_supply;     // Write to supply control
  logic [DATA_W-1:0] next_rdata;    // Read mux output

  // Derived wake terms
  logic              button_en;     // Button enable bit
  logic              alarm_en;      // Alarm enable bit
  logic              override_set;  // Override flag set
  logic              alarm_term;    // Enabled, unblocked alarm
  logic              alarm_term_d;  // Previous alarm term
  logic              button_term;   // Enabled button flag
  logic              next_pme;      // Event output condition
  logic              next_wake;     // Wake strobe condition
  logic              next_irq;      // Interrupt condition

  // Source wiring: general vector in status bit order
  assign gp_ev.raw = {combined_event,       // Bit 7
                      ring_indicator_n,     // Bit 6
                      special_key,          // Bit 5
                      mouse_data,           // Bit 4
                      keyboard_data,        // Bit 3
                      gp_pin};              // Bits 2..0

  // Falling-edge sources are turned round here, software adds its own
  assign gp_ev.invert = GP_FALL_DEFAULT ^ gp_polarity;

  // Main sources: button pressed is a falling edge of the active-low pin
  assign mn_ev.raw[MI_BUTTON]   = power_button_input_n;
  assign mn_ev.raw[MI_ALARM]    = alarm_in;
  assign mn_ev.raw[MI_OVERRIDE] = override_in;
  assign mn_ev.invert           = MAIN_FALL_DEFAULT;

  // Edge detection for both groups
  wes_edge_detect #(.W(GP_N)) u_gp_det (
    .core_clk (core_clk),
    .reset    (reset),
    .ev       (gp_ev)
  );

  wes_edge_detect #(.W(MAIN_N)) u_mn_det (
    .core_clk (core_clk),
    .reset    (reset),
    .ev       (mn_ev)
  );

  // General flags: rising edges on pins a, b, c, special key, combined; falling edges on keyboard, mouse, ring
  wes_flag_bank #(.W(GP_N)) u_gp_flags (
    .core_clk (core_clk),
    .ev       (gp_ev)
  );

  // Main flags: button, alarm, override
  wes_flag_bank #(.W(MAIN_N)) u_mn_flags (
    .core_clk (core_clk),
    .ev       (mn_ev)
  );

  // General status cleared by the standby power reset
  assign gp_ev.rst_bits = {GP_N{reset}};

  // Button flag follows standby reset; alarm and override follow battery
  assign mn_ev.rst_bits[MI_BUTTON]   = reset;
  assign mn_ev.rst_bits[MI_ALARM]    = battery_reset;
  assign mn_ev.rst_bits[MI_OVERRIDE] = battery_reset;

  // Address decode, writes only
  assign wr_enable   = reg_wr && (reg_addr == OFS_ENABLE_MAIN);
  assign wr_gp_stat  = reg_wr && (reg_addr == OFS_GP_STATUS_LOW);
  assign wr_mn_stat  = reg_wr && (reg_addr == OFS_MAIN_STATUS);
  assign wr_mn_mask  = reg_wr && (reg_addr == OFS_MAIN_MASK);
  assign wr_gp_mask  = reg_wr && (reg_addr == OFS_GP_MASK);
  assign wr_polarity = reg_wr && (reg_addr == OFS_GP_POLARITY);
  assign wr_supply   = reg_wr && (reg_addr == OFS_SUPPLY_CTRL);

  // One-writes clear general flags; zeros leave them alone
  assign gp_ev.clr = wr_gp_stat ? reg_wdata : '0;

  // One-writes clear main flags at their layout positions
  assign mn_ev.clr[MI_BUTTON] = wr_mn_stat && reg_wdata[BIT_BUTTON];
  assign mn_ev.clr[MI_ALARM]  = wr_mn_stat && reg_wdata[BIT_ALARM];
  assign mn_ev.clr[MI_OVERRIDE] = wr_mn_stat && reg_wdata[BIT_OVERRIDE];

  // Main flags placed into register layout, other bits zero
  always_comb begin
    main_status               = RST_BYTE;
    main_status[BIT_BUTTON]   = mn_ev.flags[MI_BUTTON];
    main_status[BIT_ALARM]    = mn_ev.flags[MI_ALARM];
    main_status[BIT_OVERRIDE] = mn_ev.flags[MI_OVERRIDE];
  end

  // Enable register, cleared by either reset
  always_ff @(posedge core_clk) begin
    if (reset || battery_reset) begin
      enable_main <= RST_BYTE;
    end else if (wr_enable) begin
      enable_main <= reg_wdata & ENABLE_VALID; // Reserved bits stay zero
    end
  end

  // Interrupt masks and polarity
  always_ff @(posedge core_clk) begin
    if (reset || battery_reset) begin
      main_mask   <= RST_BYTE;
      gp_mask     <= RST_BYTE;
      gp_polarity <= RST_BYTE;
    end else begin
      if (wr_mn_mask) begin
        main_mask <= reg_wdata;
      end
      if (wr_gp_mask) begin
        gp_mask <= reg_wdata;
      end
      if (wr_polarity) begin
        gp_polarity <= reg_wdata;
      end
    end
  end

  // Enable bits used by the wake logic
  assign button_en    = enable_main[BIT_BUTTON];
  assign alarm_en     = enable_main[BIT_ALARM];
  assign override_set = mn_ev.flags[MI_OVERRIDE];

  // Alarm reaches the event, wake and supply outputs only when enabled and not overridden
  assign alarm_term  = mn_ev.flags[MI_ALARM] && alarm_en && !override_set;

  // Button reaches the event output only when enabled
  assign button_term = mn_ev.flags[MI_BUTTON] && button_en;

  // Event output condition
  assign next_pme = button_term || alarm_term;

  // Wake: any press, or a newly raised alarm term
  assign next_wake = mn_ev.hit[MI_BUTTON] || (alarm_term && !alarm_term_d);

  // Interrupt: any unmasked flag
  assign next_irq = |(main_status & main_mask) ||
                    |(gp_ev.flags & gp_mask);

  // Output registers for event, wake and interrupt
  always_ff @(posedge core_clk) begin
    if (reset) begin
      power_event_output_n <= 1'b1;
      wake_pulse           <= 1'b0;
      irq                  <= 1'b0;
      alarm_term_d         <= 1'b0;
    end else begin
      power_event_output_n <= !next_pme;
      wake_pulse           <= next_wake;
      irq                  <= next_irq;
      alarm_term_d         <= alarm_term;
    end
  end

  // Supply control: override forces off, wake beats sleep
  always_ff @(posedge core_clk) begin
    if (reset) begin
      supply_on <= 1'b0;
    end else if (mn_ev.hit[MI_OVERRIDE]) begin
      supply_on <= 1'b0;                      // Held button turns off
    end else if (next_wake) begin
      supply_on <= 1'b1;
    end else if (wr_supply && reg_wdata[BIT_SLEEP]) begin
      supply_on <= 1'b0;                      // Software sleep
    end
  end

  // Active-low supply pin
  always_ff @(posedge core_clk) begin
    if (reset) supply_on_output_n <= 1'b1;
    else supply_on_output_n <= !(supply_on || next_wake);
  end

  // Read mux, unmapped offsets read zero
  always_comb begin
    next_rdata = RST_BYTE;
    case (reg_addr)
      OFS_ENABLE_RSVD:   next_rdata = RST_BYTE;
      OFS_ENABLE_MAIN:   next_rdata = enable_main;
      OFS_GP_STATUS_LOW: next_rdata = gp_ev.flags;
      OFS_MAIN_STATUS:   next_rdata = main_status;
      OFS_MAIN_MASK:     next_rdata = main_mask;
      OFS_GP_MASK:       next_rdata = gp_mask;
      OFS_GP_POLARITY:   next_rdata = gp_polarity;
      OFS_SUPPLY_CTRL: begin
        next_rdata[BIT_SUPPLY] = supply_on;
      end
      default:           next_rdata = RST_BYTE;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (reset) reg_rdata <= RST_BYTE;
    else if (reg_rd) reg_rdata <= next_rdata;
    else reg_rdata <= RST_BYTE;
  end
endmodule : wes_wake_top

// *** verif/wes_wake_top_sva.sv ***
// Concurrent checks on the wake event block, bound to its top ports.
// Assumes one clock domain and host strobes that never overlap.
`timescale 1ns/1ns
module wes_wake_top_sva
  import wes_pkg::*;
(
  input wire logic              core_clk,             // Clock
  input wire logic              reset,                // Standby reset
  input wire logic              battery_reset,        // Battery reset
  input wire logic [ADDR_W-1:0] reg_addr,             // Address
  input wire logic [DATA_W-1:0] reg_wdata,            // Write data
  input wire logic              reg_wr,               // Write strobe
  input wire logic              reg_rd,               // Read strobe
  input wire logic [DATA_W-1:0] reg_rdata,            // Read data
  input wire logic              power_button_input_n, // Button
  input wire logic              alarm_in,             // Alarm
  input wire logic              override_in,          // Override
  input wire logic [2:0]        gp_pin,               // Pins a, b, c
  input wire logic              keyboard_data,        // Keyboard
  input wire logic              mouse_data,           // Mouse
  input wire logic              special_key,          // Special key
  input wire logic              ring_indicator_n,     // Ring
  input wire logic              combined_event,       // All events
  input wire logic              supply_on_output_n,   // Supply on
  input wire logic              power_event_output_n, // Power event
  input wire logic              wake_pulse            // Wake strobe
);
  logic [7:0] srcs;     // Sources in status order
  logic [7:0] srcs_q;   // Previous sample
  logic [7:0] quiet;    // Cycles with no source change
  logic [7:0] en_main;  // Shadow of main enable
  logic       ovr_seen; // Override seen since battery reset

  assign srcs = {combined_event, ring_indicator_n, special_key, mouse_data,
                 keyboard_data, gp_pin};
  // Quiet count; a polarity write may make an edge as well
  always_ff @(posedge core_clk) begin
    srcs_q <= srcs;
    if (reset || srcs != srcs_q || (reg_wr && reg_addr == OFS_GP_POLARITY)) begin
      quiet <= 8'h00;
    end else if (quiet != 8'hff) begin
      quiet <= quiet + 8'h01;
    end
  end
  // Enables as software wrote them
  always_ff @(posedge core_clk) begin
    if (reset || battery_reset) begin
      en_main <= 8'h00;
    end else if (reg_wr && reg_addr == OFS_ENABLE_MAIN) begin
      en_main <= reg_wdata & ENABLE_VALID;
    end
  end
  // Override blocks alarm events; only battery reset forgets it here
  always_ff @(posedge core_clk) begin
    if (battery_reset) begin
      ovr_seen <= 1'b0;
    end else if (override_in) begin
      ovr_seen <= 1'b1;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  // Enable write then its read back
  sequence s_en_wr_rd;
    reg_wr && reg_addr == OFS_ENABLE_MAIN && !battery_reset
      ##1 reg_rd && reg_addr == OFS_ENABLE_MAIN && !battery_reset;
  endsequence
  // Status clear then read, with no edge in flight
  sequence s_st_wr_rd;
    reg_wr && reg_addr == OFS_GP_STATUS_LOW
      ##1 reg_rd && reg_addr == OFS_GP_STATUS_LOW && quiet >= 8'h04;
  endsequence
  // Button pressed
  sequence s_press;
    $fell(power_button_input_n);
  endsequence

  chk_rsvd_reads_zero: assert property (
    reg_rd && reg_addr == OFS_ENABLE_RSVD |=> reg_rdata == 8'h00)
    else $error("Reserved enable read not zero");
  chk_enable_read_back: assert property (
    s_en_wr_rd |=> reg_rdata == ($past(reg_wdata, 2) & ENABLE_VALID))
    else $error("Main enable read back wrong");
  chk_button_wakes: assert property (
    s_press |-> ##[1:6] (wake_pulse && !supply_on_output_n))
    else $error("Button press gave no wake");
  chk_wake_one_cycle: assert property (
    wake_pulse |=> !wake_pulse)
    else $error("Wake strobe longer than one cycle");
  chk_button_flag_set: assert property (
    s_press ##[3:12] (reg_rd && reg_addr == OFS_MAIN_STATUS) |=> reg_rdata[BIT_BUTTON])
    else $error("Button flag not set after press");
  chk_disabled_silent: assert property (
    (en_main[BIT_ALARM] == 1'b0 && en_main[BIT_BUTTON] == 1'b0) [*2]
      |-> power_event_output_n)
    else $error("Power event with sources disabled");
  chk_alarm_event: assert property (
    en_main[BIT_ALARM] && !ovr_seen && $rose(alarm_in) |-> ##[2:7] !power_event_output_n)
    else $error("Enabled alarm gave no power event");
  chk_status_clears: assert property (
    s_st_wr_rd |=> (reg_rdata & $past(reg_wdata, 2)) == 8'h00)
    else $error("Status bit survived a one write");
endmodule : wes_wake_top_sva

bind wes_wake_top wes_wake_top_sva chk_u (
  .core_clk(core_clk), .reset(reset), .battery_reset(battery_reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .power_button_input_n(power_button_input_n),
  .alarm_in(alarm_in), .override_in(override_in), .gp_pin(gp_pin),
  .keyboard_data(keyboard_data), .mouse_data(mouse_data), .special_key(special_key),
  .ring_indicator_n(ring_indicator_n), .combined_event(combined_event),
  .supply_on_output_n(supply_on_output_n),
  .power_event_output_n(power_event_output_n), .wake_pulse(wake_pulse));

// *** verif/wes_src_model.sv ***
// Far-side event sources: pins, keys, ring, alarm, override, button.
// Assumes the bench calls drive right after a rising clock edge.
`timescale 1ns/1ns
module wes_src_model
  import wes_pkg::*;
(
  output logic [GP_N-1:0] src,      // General sources, status order
  output logic            button_n, // Button, low pressed
  output logic            alarm,    // Alarm level
  output logic            ovr       // Override level
);
  // Idle levels; falling-edge sources rest high
  initial begin
    src = GP_FALL_DEFAULT;
    button_n = 1'b1;
    alarm = 1'b0;
    ovr = 1'b0;
  end
  // Index 0..7 general, 8 button, 9 alarm, 10 override
  task automatic drive(input int idx, input logic v);
    case (idx)
      8: button_n <= v;
      9: alarm <= v;
      10: ovr <= v;
      default: src[idx[2:0]] <= v;
    endcase
  endtask : drive
endmodule : wes_src_model

// *** verif/wes_wake_top_test.sv ***
// Self-checking bench for the wake event block.
// Assumes the source model and the bound checker are compiled alongside.
`timescale 1ns/1ns
module wes_wake_top_test;
  import wes_pkg::*;
  logic       core_clk = 1'b0;      // 50 MHz clock
  logic       reset = 1'b1;         // Standby reset
  logic       battery_reset = 1'b1; // Battery reset
  logic [7:0] reg_addr = 8'h00;     // Register address
  logic [7:0] reg_wdata = 8'h00;    // Write data
  logic       reg_wr = 1'b0;        // Write strobe
  logic       reg_rd = 1'b0;        // Read strobe
  logic [7:0] reg_rdata;            // Read data
  logic [7:0] src;                  // General sources
  logic       button_n, alarm, ovr; // Model levels
  logic       supply_n, pe_n, wake, irq; // Outputs
  int         n_fail = 0;           // Mismatches
  int         check_count = 0;      // Comparisons
  int         cyc = 0;              // Timeout count

  always #10 core_clk = ~core_clk;

  wes_src_model pm_u (.src(src), .button_n(button_n), .alarm(alarm), .ovr(ovr));
  wes_wake_top dut_u (
    .core_clk(core_clk), .reset(reset), .battery_reset(battery_reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .power_button_input_n(button_n), .alarm_in(alarm),
    .override_in(ovr), .gp_pin(src[2:0]), .keyboard_data(src[3]),
    .mouse_data(src[4]), .special_key(src[5]), .ring_indicator_n(src[6]),
    .combined_event(src[7]), .supply_on_output_n(supply_n),
    .power_event_output_n(pe_n), .wake_pulse(wake), .irq(irq));

  task automatic close_out;
    $display("Checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : wait_cyc
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read, data stands in the next cycle only
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp);
    @(posedge core_clk);
  endtask : rdc
  // Poll for the wake strobe, bounded
  task automatic wait_wake;
    int k;
    k = 0;
    #1;
    while (wake !== 1'b1 && k < 10) begin
      @(posedge core_clk);
      #1 k++;
    end
    check({7'h00, wake}, 8'h01);
    @(posedge core_clk);
  endtask : wait_wake

  task automatic t_regs;
    rdc(OFS_ENABLE_RSVD, 8'h00);
    rdc(OFS_GP_STATUS_LOW, 8'h00);
    rdc(8'h00, 8'h00);
    wr(OFS_ENABLE_RSVD, 8'hff);
    rdc(OFS_ENABLE_RSVD, 8'h00);
    wr(OFS_ENABLE_MAIN, 8'hff);
    rdc(OFS_ENABLE_MAIN, ENABLE_VALID);
    wr(OFS_ENABLE_MAIN, 8'h00);
  endtask : t_regs
  // Each source: active edge sets, return edge not, inverted swaps
  task automatic t_gp_edges;
    logic idle;
    for (int i = 0; i < 8; i++) begin
      idle = GP_FALL_DEFAULT[i];
      pm_u.drive(i, !idle);
      wait_cyc(8);
      rdc(OFS_GP_STATUS_LOW, 8'h01 << i);
      wr(OFS_GP_STATUS_LOW, ~(8'h01 << i));
      rdc(OFS_GP_STATUS_LOW, 8'h01 << i);
      wr(OFS_GP_STATUS_LOW, 8'h01 << i);
      pm_u.drive(i, idle);
      wait_cyc(8);
      rdc(OFS_GP_STATUS_LOW, 8'h00);
      wr(OFS_GP_POLARITY, 8'h01 << i);
      wait_cyc(8);
      wr(OFS_GP_STATUS_LOW, 8'hff);
      pm_u.drive(i, !idle);
      wait_cyc(8);
      rdc(OFS_GP_STATUS_LOW, 8'h00);
      pm_u.drive(i, idle);
      wait_cyc(8);
      rdc(OFS_GP_STATUS_LOW, 8'h01 << i);
      wr(OFS_GP_POLARITY, 8'h00);
      wait_cyc(8);
      wr(OFS_GP_STATUS_LOW, 8'hff);
    end
  endtask : t_gp_edges
  task automatic t_button;
    pm_u.drive(8, 1'b0);
    wait_wake();
    check({7'h00, supply_n}, 8'h00);
    check({7'h00, pe_n}, 8'h01);
    rdc(OFS_MAIN_STATUS, 8'h01);
    pm_u.drive(8, 1'b1);
    wr(OFS_MAIN_STATUS, 8'h01);
    wait_cyc(1);
    wr(OFS_ENABLE_MAIN, 8'h01);
    pm_u.drive(8, 1'b0);
    wait_cyc(8);
    check({7'h00, pe_n}, 8'h00);
    pm_u.drive(8, 1'b1);
    wr(OFS_MAIN_STATUS, 8'h01);
    wait_cyc(1);
    wr(OFS_ENABLE_MAIN, 8'h00);
  endtask : t_button
  task automatic t_alarm;
    pm_u.drive(9, 1'b1);
    wait_cyc(8);
    rdc(OFS_MAIN_STATUS, 8'h04);
    check({7'h00, pe_n}, 8'h01);
    wr(OFS_MAIN_MASK, 8'h04);
    wait_cyc(2);
    check({7'h00, irq}, 8'h01);
    wr(OFS_MAIN_MASK, 8'h00);
    wait_cyc(2);
    check({7'h00, irq}, 8'h00);
    pm_u.drive(9, 1'b0);
    wr(OFS_MAIN_STATUS, 8'h04);
    wait_cyc(1);
    wr(OFS_ENABLE_MAIN, 8'h04);
    pm_u.drive(9, 1'b1);
    wait_cyc(8);
    check({7'h00, pe_n}, 8'h00);
    pm_u.drive(0, 1'b1);
    wait_cyc(8);
    wr(OFS_GP_MASK, 8'h01);
    wait_cyc(2);
    check({7'h00, irq}, 8'h01);
    reset <= 1'b1;
    wait_cyc(2);
    reset <= 1'b0;
    @(posedge core_clk);
    rdc(OFS_GP_STATUS_LOW, 8'h00);
    rdc(OFS_MAIN_STATUS, 8'h04);
    battery_reset <= 1'b1;
    wait_cyc(2);
    battery_reset <= 1'b0;
    @(posedge core_clk);
    rdc(OFS_MAIN_STATUS, 8'h00);
    pm_u.drive(9, 1'b0);
    pm_u.drive(0, 1'b0);
  endtask : t_alarm
  task automatic t_override;
    wr(OFS_ENABLE_MAIN, 8'h04);
    pm_u.drive(10, 1'b1);
    wait_cyc(8);
    pm_u.drive(9, 1'b1);
    wait_cyc(8);
    check({7'h00, pe_n}, 8'h01);
    pm_u.drive(8, 1'b0);
    wait_wake();
    rdc(OFS_SUPPLY_CTRL, 8'h01);
    wr(OFS_SUPPLY_CTRL, 8'h01);
    rdc(OFS_SUPPLY_CTRL, 8'h00);
    check({7'h00, supply_n}, 8'h01);
  endtask : t_override

  // Hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      close_out();
    end
  end
  initial begin
    wait_cyc(8);
    reset <= 1'b0;
    battery_reset <= 1'b0;
    @(posedge core_clk);
    t_regs();
    t_gp_edges();
    t_button();
    t_alarm();
    t_override();
    close_out();
  end
endmodule : wes_wake_top_test
